// [rtl/sslp_defines.svh]
// timing constants and field widths of the sleep-mode controller
`ifndef SSLP_DEFINES_SVH
`define SSLP_DEFINES_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SSLP_CLK_PERIOD_NS     8
`define SSLP_ENTRY_CYCLES      2
`define SSLP_RECOVERY_NS       20
// least time: round up, at least one cycle
`define SSLP_RECOVERY_CYCLES   ((`SSLP_RECOVERY_NS + `SSLP_CLK_PERIOD_NS - 1) / `SSLP_CLK_PERIOD_NS)
`define SSLP_CNT_W             4

// ----------------------------------------------------------------------
// memory shape
// ----------------------------------------------------------------------
`define SSLP_ADDR_W            4
`define SSLP_DATA_W            8

`endif

// [rtl/sslp_pkg.sv]
// types shared by both ends of the sleep-mode link
package sslp_pkg;

  // ----------------------------------------------------------------------
  // commands on the link
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSLP_CMD_DESELECT = 2'h0,
    SSLP_CMD_READ     = 2'h1,
    SSLP_CMD_WRITE    = 2'h2,
    SSLP_CMD_DUMMY    = 2'h3
  } sslp_cmd_t;

  typedef enum logic [1:0] {
    SSLP_AWAKE,
    SSLP_ENTERING,
    SSLP_ASLEEP,
    SSLP_RECOVER
  } sslp_pwr_t;

endpackage : sslp_pkg

// [rtl/sslp_if.sv]
// link between the memory controller and the sleep-capable sram
`include "sslp_defines.svh"

interface sslp_if;
  import sslp_pkg::*;

  logic                      sleep_request;
  sslp_cmd_t                 cmd;
  logic [`SSLP_ADDR_W-1:0]   addr;
  logic [`SSLP_DATA_W-1:0]   wdata;
  logic [`SSLP_DATA_W-1:0]   rdata;
  logic                      rdata_oe;
  logic                      rdata_valid;
  logic                      asleep;

  modport device (
    input  sleep_request,
    input  cmd,
    input  addr,
    input  wdata,
    output rdata,
    output rdata_oe,
    output rdata_valid,
    output asleep
  );

  modport ctrl (
    output sleep_request,
    output cmd,
    output addr,
    output wdata,
    input  rdata,
    input  rdata_oe,
    input  rdata_valid,
    input  asleep
  );
endinterface : sslp_if

// [rtl/sslp_device.sv]
// sleep-mode entry and exit of a synchronous sram end
//
// How it works
// (R01) sleep taken two cycles after request; the code takes it four cycles after the request
// (R02) array and state kept through sleep
// (R03) asleep: deselected, inputs ignored, outputs floated
// (R04) request held low in normal operation
// (R05) resume after recovery time once request low
// (R06) controller drains pending operations before sleeping
// (R07) only reads or deselects during recovery
// (R08) dummy reads at read-to-write turnarounds
// (R09) request synchronised before use
`include "sslp_defines.svh"

module sslp_device #(
  parameter int ADDR_W = `SSLP_ADDR_W,
  parameter int DATA_W = `SSLP_DATA_W
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  sslp_if.device    link
);
  import sslp_pkg::*;

  // recovery is rounded up to whole cycles, so it never falls short
  localparam int RECOV = `SSLP_RECOVERY_CYCLES;
  localparam int DEPTH = 2**ADDR_W;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // the array sits outside the record: it keeps its words through reset too
  typedef struct packed {
    logic                     sync1;
    logic                     sync2;
    sslp_pwr_t                pwr;
    logic [`SSLP_CNT_W-1:0]   cnt;
    logic [DATA_W-1:0]        rdata;
    logic                     oe;
    logic                     valid;
  } sslp_dev_t;

  sslp_dev_t         q, d;
  logic [DATA_W-1:0] mem_q [DEPTH];

  logic              req_sync;
  logic              in_sleep;
  logic              in_awake;
  logic              cmd_rd;
  logic              cmd_wr;
  logic              cmd_dummy;
  logic              accept_rd;
  logic              accept_dm;
  logic              wr_en;
  logic              active;

  // ----------------------------------------------------------------------
  // request synchroniser
  // ----------------------------------------------------------------------
  // nothing but the second flop is read; the first may still be settling
  // the two flops cost two cycles of entry latency, and of exit latency too
  assign req_sync = q.sync2;                               // R09

  // ----------------------------------------------------------------------
  // power state view
  // ----------------------------------------------------------------------
  assign in_sleep = (q.pwr == SSLP_ASLEEP);
  // entering still counts as awake: the request is not yet acted on
  assign in_awake = (q.pwr == SSLP_AWAKE) || (q.pwr == SSLP_ENTERING);
  assign active   = !in_sleep;

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    cmd_rd    = 1'b0;
    cmd_wr    = 1'b0;
    cmd_dummy = 1'b0;
    case (link.cmd)
      SSLP_CMD_DESELECT:
      begin
        // deselect launches nothing and leaves the drivers off
        cmd_rd = 1'b0;
      end
      SSLP_CMD_READ:
      begin
        cmd_rd = 1'b1;
      end
      SSLP_CMD_WRITE:
      begin
        cmd_wr = 1'b1;
      end
      SSLP_CMD_DUMMY:
      begin
        cmd_dummy = 1'b1;
      end
    endcase
  end

  // sleep ignores every command; recovery still serves reads
  assign accept_rd = active && cmd_rd;                     // R03
  assign accept_dm = active && cmd_dummy;                  // R08
  // writes wait for awake, which the controller must respect anyway
  assign wr_en     = in_awake && cmd_wr;                   // R07

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    d       = q;
    d.sync1 = link.sleep_request;                          // R04
    d.sync2 = q.sync1;                                     // R09
    d.valid = 1'b0;
    d.oe    = 1'b0;
    unique case (q.pwr)
      SSLP_AWAKE:
      begin
        if (req_sync)
          d.pwr = SSLP_ENTERING;
      end
      SSLP_ENTERING:
      begin
        // second cycle after the synchronised request; a drop aborts
        if (req_sync)
          d.pwr = SSLP_ASLEEP;                             // R01
        else
          d.pwr = SSLP_AWAKE;
      end
      SSLP_ASLEEP:
      begin
        if (!req_sync)
        begin
          d.pwr = SSLP_RECOVER;                            // R05
          d.cnt = `SSLP_CNT_W'(RECOV - 1);
        end
      end
      SSLP_RECOVER:
      begin
        // a new request goes through entry again, so sleep is always
        // taken the same two cycles after the synchronised sample
        if (req_sync)
          d.pwr = SSLP_ENTERING;                           // R01
        else if (q.cnt == '0)
          d.pwr = SSLP_AWAKE;                              // R05
        else
          d.cnt = q.cnt - `SSLP_CNT_W'(1);
      end
    endcase
    // a read launches in any awake or recovering cycle
    if (accept_rd)
    begin
      d.rdata = mem_q[link.addr];                          // R02
      d.oe    = 1'b1;
      d.valid = 1'b1;
    end
    // a dummy read launches like a read but ends with the drivers off
    if (accept_dm)
    begin
      d.rdata = mem_q[link.addr];
      d.oe    = 1'b0;                                      // R08
      d.valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '{sync1: 1'b0,
             sync2: 1'b0,
             pwr:   SSLP_AWAKE,
             cnt:   '0,
             rdata: '0,
             oe:    1'b0,
             valid: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // array
  // ----------------------------------------------------------------------
  // no reset: contents survive sleep and reset alike; one write port a word
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_word
    always_ff @(posedge clk_sys)
    begin
      if (wr_en && link.addr == ADDR_W'(i))
        mem_q[i] <= link.wdata;                            // R02
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // masked from the power state so the first sleeping cycle floats at once
  assign link.rdata       = q.rdata;
  assign link.rdata_oe    = q.oe && !in_sleep;             // R03
  assign link.rdata_valid = q.valid && !in_sleep;          // R03
  assign link.asleep      = in_sleep;

endmodule : sslp_device

// [rtl/sslp_ctrl.sv]
// memory controller end that drives sleep and commands to the sram
`include "sslp_defines.svh"

module sslp_ctrl #(
  parameter int ADDR_W = `SSLP_ADDR_W,
  parameter int DATA_W = `SSLP_DATA_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  sslp_if.ctrl                        link,
  input  wire logic                   sleep_want,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [DATA_W-1:0]      req_wdata,
  output logic [DATA_W-1:0]           rsp_data,
  output logic                        rsp_valid,
  output logic                        sleeping
);
  import sslp_pkg::*;

  localparam int GUARD = `SSLP_RECOVERY_CYCLES + `SSLP_ENTRY_CYCLES + 2;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                     zz;
    logic [`SSLP_CNT_W-1:0]   guard;
    logic                     last_read;
    logic                     rd_pend;
    sslp_cmd_t                cmd;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W-1:0]        wdata;
    logic [DATA_W-1:0]        rsp;
    logic                     rvalid;
  } sslp_ctl_t;

  sslp_ctl_t q, d;
  logic      idle;
  logic      wr_ok;
  logic      turn;

  assign idle  = !q.rd_pend && q.cmd == SSLP_CMD_DESELECT;
  assign wr_ok = !q.zz && q.guard == '0;                    // R07
  assign turn  = req_write && q.last_read;                  // R08
  // a read sent while the device still sleeps would be dropped, so wait for it
  assign req_ready = !q.zz && !sleep_want && !link.asleep && (!req_write || wr_ok) && !turn;

  always_comb
  begin
    d        = q;
    d.cmd    = SSLP_CMD_DESELECT;
    d.rvalid = 1'b0;
    d.rd_pend = 1'b0;
    if (q.guard != '0)
      d.guard = q.guard - `SSLP_CNT_W'(1);
    // raise only once the link is quiet; drop as soon as unwanted
    if (sleep_want && idle)
      d.zz = 1'b1;                                          // R06
    else if (!sleep_want && q.zz)
    begin
      d.zz    = 1'b0;                                       // R04
      d.guard = `SSLP_CNT_W'(GUARD);
    end
    if (req_valid && req_ready)
    begin
      d.cmd       = req_write ? SSLP_CMD_WRITE : SSLP_CMD_READ;
      d.addr      = req_addr;
      d.wdata     = req_wdata;
      d.last_read = !req_write;
      d.rd_pend   = !req_write;
    end
    else if (req_valid && turn && !q.zz && !sleep_want)
    begin
      // costs a cycle but keeps the drivers of both ends apart
      d.cmd       = SSLP_CMD_DUMMY;                         // R08
      d.last_read = 1'b0;
    end
    if (link.rdata_valid)
    begin
      d.rsp    = link.rdata;
      d.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q <= '{zz: 1'b0, guard: '0, last_read: 1'b0, rd_pend: 1'b0,
             cmd: SSLP_CMD_DESELECT, addr: '0, wdata: '0, rsp: '0, rvalid: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign link.sleep_request = q.zz;                         // R04
  assign link.cmd           = q.cmd;
  assign link.addr          = q.addr;
  assign link.wdata         = q.wdata;
  assign rsp_data           = q.rsp;
  assign rsp_valid          = q.rvalid;
  assign sleeping           = link.asleep;

endmodule : sslp_ctrl

// [sim/sslp_monitor.sv]
// assertions on the link between the two ends
module sslp_monitor (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                sleep_request,
  input wire sslp_pkg::sslp_cmd_t cmd,
  input wire logic                rdata_oe,
  input wire logic                rdata_valid,
  input wire logic                asleep
);
  timeunit 1ns;
  timeprecision 1ns;
  import sslp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // sleep entry and exit
  // ----------------------------------------------------------------------
  chk_entry_late: assert property (sleep_request[*4] |=> asleep)
    else $error("sleep entered late");
  chk_entry_early: assert property ($rose(sleep_request) |-> !asleep[*4])
    else $error("sleep entered early");
  chk_sync_hold: assert property ($fell(sleep_request) && asleep |=> asleep)
    else $error("request used unsynchronised");
  chk_resume_bound: assert property ($fell(sleep_request) |-> ##[1:8] !asleep)
    else $error("no resume after recovery");
  chk_drain_first: assert property ($rose(sleep_request) |-> cmd == SSLP_CMD_DESELECT)
    else $error("command pending at sleep");
  chk_recov_write: assert property ($fell(asleep) |-> (cmd != SSLP_CMD_WRITE)[*3])
    else $error("write during recovery");
  // ----------------------------------------------------------------------
  // read data drivers
  // ----------------------------------------------------------------------
  chk_asleep_quiet: assert property (asleep |-> !rdata_oe && !rdata_valid)
    else $error("drivers on in sleep");
  chk_read_answer: assert property (cmd == SSLP_CMD_READ && !asleep && !sleep_request
    |=> rdata_valid && rdata_oe)
    else $error("read not answered");
  chk_dummy_off: assert property (cmd == SSLP_CMD_DUMMY |=> !rdata_oe)
    else $error("dummy read drove data");
endmodule : sslp_monitor

// [sim/tb_top.sv]
// bench joining controller and device ends
`include "sslp_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sslp_pkg::*;
  logic       clk_sys, rst, sleep_want, req_valid, req_write;
  logic       req_ready, rsp_valid, sleeping;
  logic [3:0] req_addr;
  logic [7:0] req_wdata, rsp_data;
  int         fails, check_count, n;
  sslp_if link();
  sslp_device u_sslp_device (.clk_sys(clk_sys), .rst(rst), .link(link));
  sslp_ctrl u_sslp_ctrl (.clk_sys(clk_sys), .rst(rst), .link(link),
    .sleep_want(sleep_want), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .sleeping(sleeping));
  sslp_monitor u_sslp_monitor (.clk_sys(clk_sys), .rst(rst),
    .sleep_request(link.sleep_request), .cmd(link.cmd), .rdata_oe(link.rdata_oe),
    .rdata_valid(link.rdata_valid), .asleep(link.asleep));
  initial
  begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait on a settled level; running out ends the run
  task automatic await(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 80)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (s !== v)
    begin
      cmp(8'h0, 8'h1);
      conclude();
    end
  endtask : await
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    #1;
    await(req_ready, 1'h1);
    @(negedge clk_sys);
    req_valid = 1'h0;
    // one idle cycle, so a second call never re-raises valid in this step
    @(negedge clk_sys);
  endtask : xfer
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    xfer(1'h0, a, 8'h0);
    await(rsp_valid, 1'h1);
    // answer stands after the third edge from the take; xfer waited two
    cmp(8'(n), 8'h1);
    cmp(rsp_data, exp);
  endtask : rd
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial
  begin
    rst = 1'h1;
    sleep_want = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 4'h0;
    req_wdata = 8'h0;
    repeat (12) @(negedge clk_sys);
    rst = 1'h0;
    cmp({7'h0, link.sleep_request}, 8'h0);
    for (int i = 0; i < 4; i++)
      xfer(1'h1, 4'(i), {4'ha, 4'(i)});
    rd(4'h3, 8'ha3);
    xfer(1'h1, 4'h3, 8'h7e);
    rd(4'h3, 8'h7e);
    sleep_want = 1'h1;
    await(link.sleep_request, 1'h1);
    await(link.asleep, 1'h1);
    cmp(8'(n), 8'(`SSLP_ENTRY_CYCLES + 2));
    repeat (5)
    begin
      @(negedge clk_sys);
      cmp({link.rdata_oe, req_ready, sleeping}, 8'h1);
    end
    sleep_want = 1'h0;
    await(sleeping, 1'h0);
    rd(4'h1, 8'ha1);
    xfer(1'h1, 4'h1, 8'h3c);
    rd(4'h1, 8'h3c);
    conclude();
  end
endmodule : tb_top
